/* File: dv/tpi_host.sv */
// host model that drives the register port of the threshold irq block
`timescale 1ns/1ps
module tpi_host (
  input wire logic i_mclk,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle bus values
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // one byte write; the released bus shows inverted values so stale data never passes
  task automatic wr_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_mclk);
    o_wr <= 1'b1;
    o_addr <= addr;
    o_wdata <= data;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_addr <= ~addr;
    o_wdata <= ~data;
  endtask : wr_byte

  // one byte read; the answer strobe is looked at in the one cycle it stands
  task automatic rd_byte(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge i_mclk);
    o_rd <= 1'b1;
    o_addr <= addr;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_addr <= ~addr;
    #1;
    ok = i_rvalid;
    data = i_rdata;
  endtask : rd_byte
endmodule : tpi_host

/* File: dv/tpi_irq_tb.sv */
// self-checking testbench of the threshold irq block
`timescale 1ns/1ps
module tpi_irq_tb;
  import tpi_pkg::*;
  logic i_mclk, i_rstn, wr, rd, rvalid, av, pv, aen, pen, aclr, pclr, aflag, pflag, int_n;
  logic [7:0] addr, wdata, rdata, pres;
  logic [15:0] ares;
  int failures, n_checks;
  logic [3:0] acode [5] = '{4'h2, 4'h3, 4'h4, 4'h7, 4'hF}; // als codes under test
  int aneed [5] = '{2, 3, 5, 20, 60}; // decoded run lengths
  logic [7:0] regs [7] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h8A, 8'h8C};

  tpi_host host (.i_mclk(i_mclk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));
  tpi_irq dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_als_valid(av), .i_als_result(ares), .i_prox_valid(pv), .i_prox_result(pres),
    .i_als_irq_enable(aen), .i_prox_irq_enable(pen), .i_als_irq_clr(aclr),
    .i_prox_irq_clr(pclr), .o_als_irq_flag(aflag), .o_prox_irq_flag(pflag),
    .o_int_n(int_n));

  ////////////////////////////////////////////////////////////////////////////////
  // compare tasks and verdict
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  // bus and result helpers
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd_byte(a, d, ok);
    chk_bit(ok, 1'b1, "rvalid");
    chk_byte(d, exp);
  endtask : rd_chk

  // low byte first, high byte straight after, so the pair latches as one word
  task automatic wr_pair(input logic [7:0] a, input logic [15:0] v);
    host.wr_byte(a, v[7:0]);
    host.wr_byte(a + 8'h01, v[15:8]);
  endtask : wr_pair

  // each result pulse is followed by an idle edge, so valid is never set twice at once
  task automatic als_run(input logic [15:0] v, input int n);
    repeat (n) begin
      @(posedge i_mclk);
      av <= 1'b1;
      ares <= v;
      @(posedge i_mclk);
      av <= 1'b0;
    end
  endtask : als_run

  task automatic prox_run(input logic [7:0] v, input int n);
    repeat (n) begin
      @(posedge i_mclk);
      pv <= 1'b1;
      pres <= v;
      @(posedge i_mclk);
      pv <= 1'b0;
    end
  endtask : prox_run

  // clear both flags and let the flag outputs settle
  task automatic clear_flags;
    @(posedge i_mclk);
    aclr <= 1'b1;
    pclr <= 1'b1;
    @(posedge i_mclk);
    aclr <= 1'b0;
    pclr <= 1'b0;
    settle();
  endtask : clear_flags

  task automatic settle;
    @(posedge i_mclk);
    #1;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {failures, n_checks} = '0;
    {i_rstn, av, pv, aen, pen, aclr, pclr} = '0;
    ares = 16'h0000;
    pres = 8'h00;
    repeat (5) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    foreach (regs[i]) rd_chk(regs[i], 8'h00);
    rd_chk(8'h89, 8'h00);
    host.wr_byte(ADDR_PERSIST, 8'h01);
    wr_pair(ADDR_ALS_LO_LOW, 16'h0100);
    wr_pair(ADDR_ALS_HI_LOW, 16'h8000);
    rd_chk(ADDR_ALS_LO_HIGH, 8'h01);
    aen <= 1'b1;
    als_run(16'h0100, 1);
    settle();
    chk_bit(aflag, 1'b0, "als flag equal low");
    als_run(16'h00FF, 1);
    settle();
    chk_bit(aflag, 1'b1, "als flag below");
    chk_bit(int_n, 1'b0, "pin als");
    clear_flags();
    chk_bit(int_n, 1'b1, "pin after clear");
    host.wr_byte(ADDR_ALS_LO_LOW, 8'hFF);
    als_run(16'h0100, 1);
    settle();
    chk_bit(aflag, 1'b0, "als low byte alone");
    rd_chk(ADDR_ALS_LO_LOW, 8'hFF);
    als_run(16'h8001, 1);
    als_run(16'h2000, 2);
    settle();
    chk_bit(aflag, 1'b1, "als above, sticky");
    aen <= 1'b0;
    settle();
    chk_bit(int_n, 1'b1, "pin als disabled");
    foreach (acode[i]) begin
      host.wr_byte(ADDR_PERSIST, {4'h0, acode[i]});
      als_run(16'h2000, 1);
      clear_flags();
      als_run(16'h0000, aneed[i] - 1);
      als_run(16'h2000, 1);
      als_run(16'hFFFF, aneed[i] - 1);
      settle();
      chk_bit(aflag, 1'b0, "als run short");
      als_run(16'hFFFF, 1);
      settle();
      chk_bit(aflag, 1'b1, "als run reached");
    end
    host.wr_byte(ADDR_PROX_LOW, 8'h10);
    host.wr_byte(ADDR_PROX_HIGH, 8'h80);
    pen <= 1'b1;
    for (int c = 1; c <= 15; c += 7) begin
      host.wr_byte(ADDR_PERSIST, {c[3:0], 4'h1});
      prox_run(8'h50, 1);
      clear_flags();
      prox_run(8'h05, c - 1);
      prox_run(8'h10, 1);
      prox_run(8'h90, c - 1);
      settle();
      chk_bit(pflag, 1'b0, "prox run short");
      prox_run(8'h90, 1);
      settle();
      chk_bit(pflag, 1'b1, "prox run reached");
      chk_bit(int_n, 1'b0, "pin prox");
    end
    host.wr_byte(ADDR_PERSIST, 8'hF0);
    clear_flags();
    prox_run(8'h05, 70);
    settle();
    chk_bit(pflag, 1'b0, "prox no refire");
    host.wr_byte(ADDR_PERSIST, 8'h00);
    prox_run(8'h50, 1);
    als_run(16'h2000, 1);
    settle();
    chk_bit(pflag, 1'b1, "prox every cycle");
    chk_bit(aflag, 1'b1, "als every cycle");
    end_of_test();
  end
endmodule : tpi_irq_tb

/* File: rtl/tpi_irq.sv */
// threshold compare and persistence filter interrupt logic for als and proximity results
//
// How it works
// - als result below low threshold sets flag
// - als result above high threshold sets flag
// - enabled als flag drives interrupt pin
// - low byte buffered, latched with high byte
// - prox result below low threshold sets flag
// - prox result above high threshold sets flag
// - enabled prox flag drives interrupt pin
// - prox persistence code is count, zero every
// - als code decodes to 0,1,2,3,5..60 results
// - prox flag when run count equals setting
// - in-range prox result clears its counter
// - als flag when run count equals setting
// - in-range als result clears its counter
// - als low threshold low byte at 0x84
`timescale 1ns/1ps
module tpi_irq (
  input wire logic i_mclk,
  input wire logic i_rstn,
  // register port from the serial interface
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // conversion results
  input wire logic i_als_valid,
  input wire logic [15:0] i_als_result,
  input wire logic i_prox_valid,
  input wire logic [7:0] i_prox_result,
  // enables and flag clears from the status and enable logic
  input wire logic i_als_irq_enable,
  input wire logic i_prox_irq_enable,
  input wire logic i_als_irq_clr,
  input wire logic i_prox_irq_clr,
  // flags and pin
  output logic o_als_irq_flag,
  output logic o_prox_irq_flag,
  output logic o_int_n
);
  import tpi_pkg::*;

  tpi_state_t s; // current state
  tpi_state_t next_s; // next state

  logic [3:0] als_code; // als_persist_code field
  logic [3:0] prox_code; // prox_persist_count field
  logic [5:0] als_need; // decoded als run length
  logic [5:0] prox_need; // prox run length
  logic als_below; // photopic result under low threshold
  logic als_above; // photopic result over high threshold
  logic als_oor; // photopic out of range
  logic prox_below; // proximity result under low threshold
  logic prox_above; // proximity result over high threshold
  logic prox_oor; // proximity out of range
  logic [5:0] als_cnt_up; // saturating increment of als counter
  logic [5:0] prox_cnt_up; // saturating increment of prox counter
  logic als_fire; // als interrupt condition this cycle
  logic prox_fire; // prox interrupt condition this cycle
  logic reg_mapped; // address hits a documented register

  ////////////////////////////////////////////////////////////////////////////////
  // als persistence decode: 0..3 count one for one, above that five per step
  function automatic logic [5:0] tpi_als_need(input logic [3:0] code);
    logic [5:0] steps;
    steps = 6'(code) - 6'(ALS_PERSISTENCE_FILTER_LINEAR_MAX);
    if (code <= ALS_PERSISTENCE_FILTER_LINEAR_MAX) begin
      tpi_als_need = 6'(code);
    end else begin
      tpi_als_need = 6'(steps * ALS_PERSISTENCE_FILTER_STEP);
    end
  endfunction : tpi_als_need

  ////////////////////////////////////////////////////////////////////////////////
  // compare and run-length logic, both channels
  always_comb begin
    als_code = s.persistence_filter[ALS_PERSISTENCE_FILTER_MSB:ALS_PERSISTENCE_FILTER_LSB];
    prox_code = s.persistence_filter[PROX_PERSISTENCE_FILTER_MSB:PROX_PERSISTENCE_FILTER_LSB];
    als_need = tpi_als_need(als_code);
    prox_need = 6'(prox_code);
    // strict compares: equal to a threshold counts as inside
    als_below = i_als_result < s.als_lo_thr;
    als_above = i_als_result > s.als_hi_thr;
    als_oor = als_below || als_above;
    prox_below = i_prox_result < s.prox_lo_thr;
    prox_above = i_prox_result > s.prox_hi_thr;
    prox_oor = prox_below || prox_above;
    // a long run would otherwise wrap and fire again spuriously
    als_cnt_up = (s.als_cnt == COUNT_MAX) ? COUNT_MAX : 6'(s.als_cnt + 6'h01);
    prox_cnt_up = (s.prox_cnt == COUNT_MAX) ? COUNT_MAX : 6'(s.prox_cnt + 6'h01);
    // code zero fires on every result, in range or not
    // code one fires on every out-of-range result, even deep in a saturated run,
    // so a flag cleared in the middle of a long excursion comes straight back
    als_fire = i_als_valid && ((als_code == PERSISTENCE_FILTER_EVERY) || (als_oor &&
               ((als_cnt_up == als_need) || (als_need == 6'h01))));
    prox_fire = i_prox_valid && ((prox_code == PERSISTENCE_FILTER_EVERY) || (prox_oor &&
                ((prox_cnt_up == prox_need) || (prox_need == 6'h01))));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state: registers, counters, flags and pin
  always_comb begin
    next_s = s;
    // register writes; only the high byte moves an active 16-bit threshold
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_ALS_LO_LOW: next_s.als_lo_buf = i_reg_wdata;
        ADDR_ALS_LO_HIGH: next_s.als_lo_thr = {i_reg_wdata, s.als_lo_buf};
        ADDR_ALS_HI_LOW: next_s.als_hi_buf = i_reg_wdata;
        ADDR_ALS_HI_HIGH: next_s.als_hi_thr = {i_reg_wdata, s.als_hi_buf};
        ADDR_PROX_LOW: next_s.prox_lo_thr = i_reg_wdata;
        ADDR_PROX_HIGH: next_s.prox_hi_thr = i_reg_wdata;
        ADDR_PERSIST: next_s.persistence_filter = i_reg_wdata;
        default: next_s.persistence_filter = s.persistence_filter; // unmapped writes are dropped
      endcase
    end
    // run counters move only on a new result
    if (i_als_valid) begin
      next_s.als_cnt = als_oor ? als_cnt_up : RST_COUNT;
    end
    if (i_prox_valid) begin
      next_s.prox_cnt = prox_oor ? prox_cnt_up : RST_COUNT;
    end
    // sticky flags; a new event in the clear cycle wins over the clear
    if (i_als_irq_clr) begin
      next_s.als_flag = 1'b0;
    end
    if (als_fire) begin
      next_s.als_flag = 1'b1;
    end
    if (i_prox_irq_clr) begin
      next_s.prox_flag = 1'b0;
    end
    if (prox_fire) begin
      next_s.prox_flag = 1'b1;
    end
    // pin is low while any enabled flag is set
    next_s.int_n = !((next_s.als_flag && i_als_irq_enable) ||
                     (next_s.prox_flag && i_prox_irq_enable));
  end

  // state register, synchronous active-low reset
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      s <= '{als_lo_buf: RST_BYTE, als_lo_thr: RST_WORD, als_hi_buf: RST_BYTE,
             als_hi_thr: RST_WORD, prox_lo_thr: RST_BYTE, prox_hi_thr: RST_BYTE,
             persistence_filter: RST_BYTE, als_cnt: RST_COUNT, prox_cnt: RST_COUNT,
             als_flag: 1'b0, prox_flag: 1'b0, int_n: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // readback lives in the byte memory; logic above keeps the active copies
  always_comb begin
    reg_mapped = (i_reg_addr == ADDR_ALS_LO_LOW) || (i_reg_addr == ADDR_ALS_LO_HIGH) ||
                 (i_reg_addr == ADDR_ALS_HI_LOW) || (i_reg_addr == ADDR_ALS_HI_HIGH) ||
                 (i_reg_addr == ADDR_PROX_LOW) || (i_reg_addr == ADDR_PROX_HIGH) ||
                 (i_reg_addr == ADDR_PERSIST);
  end

  tpi_regmem u_regmem (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_wr(i_reg_wr && reg_mapped),
    .i_idx(i_reg_addr[3:0]),
    .i_wdata(i_reg_wdata),
    .i_rd(i_reg_rd),
    .i_rd_mapped(reg_mapped),
    .o_rdata(o_reg_rdata),
    .o_rvalid(o_reg_rvalid)
  );

  assign o_als_irq_flag = s.als_flag;
  assign o_prox_irq_flag = s.prox_flag;
  assign o_int_n = s.int_n;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  als_below_set_a: assert property (
    i_als_valid && (i_als_result < s.als_lo_thr) && (als_code == 4'h1) |=> o_als_irq_flag)
    else $error("als below low threshold did not set flag");

  als_above_set_a: assert property (
    i_als_valid && (i_als_result > s.als_hi_thr) && (als_code == 4'h1) |=> o_als_irq_flag)
    else $error("als above high threshold did not set flag");

  als_pin_a: assert property (
    o_als_irq_flag && i_als_irq_enable && !i_als_irq_clr |=> !o_int_n)
    else $error("enabled als flag did not drive pin");

  thr_hold_a: assert property (
    i_reg_wr && (i_reg_addr == ADDR_ALS_LO_LOW) |=> $stable(s.als_lo_thr))
    else $error("low byte write moved active threshold");

  thr_latch_a: assert property (
    i_reg_wr && (i_reg_addr == ADDR_ALS_HI_HIGH) |=>
    s.als_hi_thr == {$past(i_reg_wdata), $past(s.als_hi_buf)})
    else $error("high byte write did not latch both bytes");

  prox_below_set_a: assert property (
    i_prox_valid && (i_prox_result < s.prox_lo_thr) && (prox_code == 4'h1) |=> o_prox_irq_flag)
    else $error("prox below low threshold did not set flag");

  prox_above_set_a: assert property (
    i_prox_valid && (i_prox_result > s.prox_hi_thr) && (prox_code == 4'h1) |=> o_prox_irq_flag)
    else $error("prox above high threshold did not set flag");

  prox_pin_a: assert property (
    o_prox_irq_flag && i_prox_irq_enable && !i_prox_irq_clr |=> !o_int_n)
    else $error("enabled prox flag did not drive pin");

  prox_every_a: assert property (
    i_prox_valid && (prox_code == 4'h0) |=> o_prox_irq_flag)
    else $error("prox code zero did not fire on result");

  als_code_five_a: assert property (
    i_als_valid && als_oor && (als_code == 4'h4) && (s.als_cnt == 6'h04) |=> o_als_irq_flag)
    else $error("als code four did not fire on fifth result");

  prox_count_up_a: assert property (
    i_prox_valid && prox_oor && (s.prox_cnt < COUNT_MAX) |=>
    s.prox_cnt == $past(s.prox_cnt) + 6'h01)
    else $error("prox counter did not advance");

  prox_count_clr_a: assert property (
    i_prox_valid && !prox_oor |=> s.prox_cnt == 6'h00)
    else $error("prox counter not cleared in range");

  als_count_clr_a: assert property (
    i_als_valid && !als_oor |=> s.als_cnt == 6'h00)
    else $error("als counter not cleared in range");

  flag_sticky_a: assert property (
    o_als_irq_flag && !i_als_irq_clr |=> o_als_irq_flag [*1])
    else $error("als flag dropped without clear");

  count_sat_a: assert property (
    i_als_valid && als_oor && (s.als_cnt == COUNT_MAX) |=> s.als_cnt == COUNT_MAX)
    else $error("als counter wrapped");

  ////////////////////////////////////////////////////////////////////////////////
  // further checks: counters, clears, pin, register copies and readback

  als_count_up_a: assert property (
    i_als_valid && als_oor && (s.als_cnt < COUNT_MAX) |=>
    s.als_cnt == $past(s.als_cnt) + 6'h01)
    else $error("als counter did not advance");

  als_count_hold_a: assert property (
    !i_als_valid |=> $stable(s.als_cnt))
    else $error("als counter moved without a result");

  prox_count_hold_a: assert property (
    !i_prox_valid |=> $stable(s.prox_cnt))
    else $error("prox counter moved without a result");

  prox_count_sat_a: assert property (
    i_prox_valid && prox_oor && (s.prox_cnt == COUNT_MAX) |=> s.prox_cnt == COUNT_MAX)
    else $error("prox counter wrapped");

  prox_sticky_a: assert property (
    o_prox_irq_flag && !i_prox_irq_clr |=> o_prox_irq_flag)
    else $error("prox flag dropped without clear");

  als_clear_a: assert property (
    i_als_irq_clr && !i_als_valid |=> !o_als_irq_flag)
    else $error("als flag not cleared");

  prox_clear_a: assert property (
    i_prox_irq_clr && !i_prox_valid |=> !o_prox_irq_flag)
    else $error("prox flag not cleared");

  pin_release_a: assert property (
    i_als_irq_clr && i_prox_irq_clr && !i_als_valid && !i_prox_valid |=> o_int_n)
    else $error("pin stayed low after both clears");

  pin_idle_a: assert property (
    !o_als_irq_flag && !o_prox_irq_flag && !i_als_valid && !i_prox_valid |=> o_int_n)
    else $error("pin low with no flag set");

  pin_masked_a: assert property (
    !i_als_irq_enable && !i_prox_irq_enable |=> o_int_n)
    else $error("pin low with both enables off");

  als_every_a: assert property (
    i_als_valid && (als_code == 4'h0) |=> o_als_irq_flag)
    else $error("als code zero did not fire on result");

  prox_code_one_a: assert property (
    i_prox_valid && prox_oor && (prox_code == 4'h1) |=> o_prox_irq_flag)
    else $error("prox code one did not fire out of range");

  als_code_one_a: assert property (
    i_als_valid && als_oor && (als_code == 4'h1) |=> o_als_irq_flag)
    else $error("als code one did not fire out of range");

  als_code_sixty_a: assert property (
    i_als_valid && als_oor && (als_code == 4'hF) && (s.als_cnt == 6'h3B) |=> o_als_irq_flag)
    else $error("als code fifteen did not fire on sixtieth result");

  als_short_a: assert property (
    !o_als_irq_flag && i_als_valid && als_oor && (als_code == 4'h4) &&
    (s.als_cnt == 6'h02) |=> !o_als_irq_flag)
    else $error("als flag set before the run was long enough");

  prox_run_a: assert property (
    i_prox_valid && prox_oor && (prox_code > 4'h1) &&
    (s.prox_cnt + 6'h01 == 6'(prox_code)) |=> o_prox_irq_flag)
    else $error("prox run equal to setting did not fire");

  lo_latch_a: assert property (
    i_reg_wr && (i_reg_addr == ADDR_ALS_LO_HIGH) |=>
    s.als_lo_thr == {$past(i_reg_wdata), $past(s.als_lo_buf)})
    else $error("low threshold high byte did not latch both bytes");

  hi_hold_a: assert property (
    i_reg_wr && (i_reg_addr == ADDR_ALS_HI_LOW) |=> $stable(s.als_hi_thr))
    else $error("high threshold low byte moved active value");

  prox_lo_wr_a: assert property (
    i_reg_wr && (i_reg_addr == ADDR_PROX_LOW) |=> s.prox_lo_thr == $past(i_reg_wdata))
    else $error("prox low threshold not written");

  prox_hi_wr_a: assert property (
    i_reg_wr && (i_reg_addr == ADDR_PROX_HIGH) |=> s.prox_hi_thr == $past(i_reg_wdata))
    else $error("prox high threshold not written");

  persistence_filter_wr_a: assert property (
    i_reg_wr && (i_reg_addr == ADDR_PERSIST) |=> s.persistence_filter == $past(i_reg_wdata))
    else $error("persistence filter not written");

  read_answer_a: assert property (
    i_reg_rd |=> o_reg_rvalid)
    else $error("read got no answer strobe");

  read_single_a: assert property (
    !i_reg_rd |=> !o_reg_rvalid)
    else $error("answer strobe without a read");

  read_lo_byte_a: assert property (
    i_reg_rd && (i_reg_addr == ADDR_ALS_LO_LOW) |=> o_reg_rdata == $past(s.als_lo_buf))
    else $error("low threshold low byte read back wrong");

endmodule : tpi_irq

/* File: rtl/tpi_pkg.sv */
// package: register map, reset values, field layout and state type of the threshold irq block
package tpi_pkg;

  // register byte addresses on the serial register port
  localparam logic [7:0] ADDR_ALS_LO_LOW = 8'h84; // als_low_thresh_low_byte
  localparam logic [7:0] ADDR_ALS_LO_HIGH = 8'h85; // als_low_thresh_high_byte
  localparam logic [7:0] ADDR_ALS_HI_LOW = 8'h86; // als_high_thresh_low_byte
  localparam logic [7:0] ADDR_ALS_HI_HIGH = 8'h87; // als_high_thresh_high_byte
  localparam logic [7:0] ADDR_PROX_LOW = 8'h88; // prox_low_threshold
  localparam logic [7:0] ADDR_PROX_HIGH = 8'h8A; // prox_high_threshold
  localparam logic [7:0] ADDR_PERSIST = 8'h8C; // persistence_filter

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00; // every threshold byte and the filter
  localparam logic [15:0] RST_WORD = 16'h0000; // active 16-bit thresholds
  localparam logic [5:0] RST_COUNT = 6'h00; // out-of-range counters

  // persistence_filter field positions
  localparam int PROX_PERSISTENCE_FILTER_MSB = 7; // prox_persist_count high bit
  localparam int PROX_PERSISTENCE_FILTER_LSB = 4; // prox_persist_count low bit
  localparam int ALS_PERSISTENCE_FILTER_MSB = 3; // als_persist_code high bit
  localparam int ALS_PERSISTENCE_FILTER_LSB = 0; // als_persist_code low bit

  // persistence decode and counting
  localparam logic [3:0] PERSISTENCE_FILTER_EVERY = 4'h0; // interrupt on every result
  localparam logic [3:0] ALS_PERSISTENCE_FILTER_LINEAR_MAX = 4'h3; // codes up to here count 1:1
  localparam logic [5:0] ALS_PERSISTENCE_FILTER_STEP = 6'h05; // five results per code above that
  localparam logic [5:0] COUNT_MAX = 6'h3F; // counters stop here instead of wrapping

  // register memory geometry: index is the low nibble of the address
  localparam int MEM_DEPTH = 16;
  localparam logic [3:0] MEM_PAGE = 4'h8; // high nibble shared by all registers

  // whole state of the top module
  typedef struct packed {
    logic [7:0] als_lo_buf; // pending low byte of the low threshold
    logic [15:0] als_lo_thr; // active als low threshold
    logic [7:0] als_hi_buf; // pending low byte of the high threshold
    logic [15:0] als_hi_thr; // active als high threshold
    logic [7:0] prox_lo_thr; // prox_low_threshold
    logic [7:0] prox_hi_thr; // prox_high_threshold
    logic [7:0] persistence_filter; // persistence_filter
    logic [5:0] als_cnt; // consecutive out-of-range photopic results
    logic [5:0] prox_cnt; // consecutive out-of-range proximity results
    logic als_flag; // als_irq_flag
    logic prox_flag; // prox_irq_flag
    logic int_n; // interrupt pin, active low
  } tpi_state_t;

  // whole state of the register memory
  typedef struct packed {
    logic [MEM_DEPTH-1:0][7:0] mem; // readback bytes
    logic [7:0] rdata; // registered read data
    logic rvalid; // read answer strobe
  } tpi_mem_t;

endpackage : tpi_pkg

/* File: rtl/tpi_regmem.sv */
// register readback memory of the threshold irq block
`timescale 1ns/1ps
module tpi_regmem (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_wr,
  input wire logic [3:0] i_idx,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  input wire logic i_rd_mapped,
  output logic [7:0] o_rdata,
  output logic o_rvalid
);
  import tpi_pkg::*;

  tpi_mem_t s; // current state
  tpi_mem_t next_s; // next state
  logic [MEM_DEPTH-1:0][7:0] next_mem; // per-entry next byte

  ////////////////////////////////////////////////////////////////////////////////
  // one write port: each entry loads only when addressed
  for (genvar e = 0; e < MEM_DEPTH; e++) begin : g_entry
    assign next_mem[e] = (i_wr && (i_idx == 4'(e))) ? i_wdata : s.mem[e];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read answers one cycle after the strobe; unmapped bytes read as zero
  always_comb begin
    next_s = s;
    next_s.mem = next_mem;
    next_s.rvalid = i_rd;
    if (i_rd) begin
      next_s.rdata = i_rd_mapped ? s.mem[i_idx] : RST_BYTE;
    end
  end

  // synchronous reset clears every byte to its documented default
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_rdata = s.rdata;
  assign o_rvalid = s.rvalid;

endmodule : tpi_regmem
